//--- include/sdsf_defs.svh
// Purpose: offsets, bit positions, codes and reset values of the status flags
// Assumes: included by its bare name from the status-flag design file only
// Notes:   definitions only
`ifndef SDSF_DEFS_SVH
`define SDSF_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SDSF_ADDR_ALIAS      8'h00
`define SDSF_ADDR_P_HIGH     8'h01
`define SDSF_ADDR_P_MID      8'h02
`define SDSF_ADDR_P_LOW      8'h03
`define SDSF_ADDR_T_HIGH     8'h04
`define SDSF_ADDR_T_LOW      8'h05
`define SDSF_ADDR_SAMPLE_ST  8'h06
`define SDSF_ADDR_FIFO_ST    8'h0d
`define SDSF_ADDR_FIFO_PORT  8'h0e

// ----------------------------------------------------------------------
// sample_status fields and reset value
// ----------------------------------------------------------------------
`define SDSF_BIT_ANY_OW      7
`define SDSF_BIT_P_OW        6
`define SDSF_BIT_T_OW        5
`define SDSF_BIT_ANY_RDY     3
`define SDSF_BIT_P_RDY       2
`define SDSF_BIT_T_RDY       1
`define SDSF_STATUS_RESET    8'h00
`define SDSF_RESERVED_READ   8'h00

// ----------------------------------------------------------------------
// fifo mode codes
// ----------------------------------------------------------------------
`define SDSF_FMODE_OFF       2'h0
`define SDSF_FMODE_CIRCULAR  2'h1
`define SDSF_FMODE_STOP      2'h2

`endif

//--- include/sdsf_pkg.sv
// Purpose: types shared by the status-flag block
// Assumes: sdsf_defs.svh holds the numbers
// Notes:   status struct packs msb first, matching the byte layout
`default_nettype none

package sdsf_pkg;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic any_overwrite_flag;
      logic pressure_overwrite_flag;
      logic temp_overwrite_flag;
      logic reserved_hi;
      logic any_ready_flag;
      logic pressure_ready_flag;
      logic temp_ready_flag;
      logic reserved_lo;
   } sdsf_status_type;

   typedef struct packed {
      logic       strobe;
      logic [7:0] addr;
   } sdsf_read_type;

   typedef struct packed {
      logic ready_event_generator_enable;
      logic pressure_event_enable;
      logic temp_event_enable;
   } sdsf_event_config_type;

   typedef enum logic [1:0] {
      SDSF_FIFO_OFF,
      SDSF_FIFO_CIRCULAR,
      SDSF_FIFO_STOP,
      SDSF_FIFO_UNUSED
   } sdsf_fifo_mode_type;

endpackage

`default_nettype wire

//--- src/sdsf_channel.sv
// Purpose: one measurement channel: result register, ready and overwrite
// Assumes: done is a one-cycle pulse carrying a complete sample
// Notes:   unread is tracked even while flag generation is off
`timescale 1ns/1ps
`default_nettype none

module sdsf_channel #(
   parameter int WIDTH = 20
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             zero,
   input  wire logic             done,
   input  wire logic [WIDTH-1:0] sample,
   input  wire logic             enable,
   input  wire logic             retrieve,
   output logic      [WIDTH-1:0] result,
   output logic                  ready,
   output logic                  overwrite,
   output logic                  unread,
   output logic                  overwriting
);

   // a new sample lands on data nobody has fetched yet
   assign overwriting = done & unread;

   // ----------------------------------------------------------------------
   // result and unread marker
   // ----------------------------------------------------------------------
   // result and ready move on the same edge, never a torn sample
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         result <= '0;
      end else if (zero) begin
         result <= '0;
      end else if (done) begin
         result <= sample;  // R21
      end
   end

   // set wins over the retrieve clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         unread <= 1'b0;
      end else if (zero) begin
         unread <= 1'b0;
      end else if (done) begin
         unread <= 1'b1;
      end else if (retrieve) begin
         unread <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // visible flags, generated only while enabled
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ready     <= 1'b0;
         overwrite <= 1'b0;
      end else if (zero) begin
         ready     <= 1'b0;
         overwrite <= 1'b0;
      end else begin
         ready     <= (done & enable) | (ready & ~retrieve);
         overwrite <= (overwriting & enable) | (overwrite & ~retrieve);
      end
   end

endmodule

`default_nettype wire

//--- src/sdsf_status_flags.sv
// Purpose: sample status flags, status alias and result read-back
// Assumes: read requests come from the serial slave on the same clock
// Notes:   fifo status and fifo data bytes are supplied from outside
`timescale 1ns/1ps
`default_nettype none

`include "sdsf_defs.svh"

// Summary of operation
// R1: address 00h shows sample status when fifo off, fifo status otherwise.
// R2: alias lets an incrementing read fetch status first, then data.
// R3: status byte at 06h, read-only, resets to 0, flags in 7..5, 3..1.
// R4: bits 4 and 0 always read as zero.
// R5: combined overwrite sets when any channel overwrites unread data.
// R6: fifo off: combined overwrite clears on either result high byte read.
// R7: fifo on: reading the fifo data port clears every flag.
// R8: pressure overwrite sets when a pressure sample replaces unread data.
// R9: fifo off: pressure overwrite clears on pressure high byte read.
// R10: temperature overwrite sets when a sample replaces unread data.
// R11: fifo off: temperature overwrite clears on temperature high byte read.
// R12: combined ready sets on any new sample, clears on high byte read.
// R13: pressure ready sets per sample, clears on pressure high byte read.
// R14: temperature ready sets per sample, clears on its high byte read.
// R15: combined flags generated only with the ready event generator on.
// R16: pressure flags generated only with pressure event enable set.
// R17: temperature flags generated only with temperature event enable set.
// R18: fifo off: results hold live data, altitude or pressure by mode.
// R19: fifo mode 00 off, 01 circular, 10 full stop.
// R20: status and results zeroed on entering active mode.
// R21: result and its ready flag update in the same cycle.
module sdsf_status_flags #(
   parameter int P_WIDTH = 20,
   parameter int T_WIDTH = 12
) (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          active_mode,
   input  wire logic [1:0]                    fifo_mode,
   input  wire sdsf_pkg::sdsf_event_config_type event_config,
   input  wire logic                          height_mode_select,
   input  wire logic                          p_done,
   input  wire logic [P_WIDTH-1:0]            p_sample,
   input  wire logic                          t_done,
   input  wire logic [T_WIDTH-1:0]            t_sample,
   input  wire logic [7:0]                    fifo_status,
   input  wire logic [7:0]                    fifo_data,
   input  wire sdsf_pkg::sdsf_read_type       rd,
   output logic      [7:0]                    rd_data,
   output logic                               rd_valid,
   output sdsf_pkg::sdsf_status_type          sample_status,
   output logic                               pressure_is_altitude
);
   import sdsf_pkg::*;

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   sdsf_fifo_mode_type    mode;
   logic                  fifo_on;
   logic                  active_prev;
   logic                  zero;
   logic                  p_fetch;
   logic                  t_fetch;
   logic                  fifo_fetch;
   logic                  p_retrieve;
   logic                  t_retrieve;
   logic                  any_retrieve;
   logic [P_WIDTH-1:0]    p_result;
   logic [T_WIDTH-1:0]    t_result;
   logic                  p_unread;
   logic                  t_unread;
   logic                  p_overwriting;
   logic                  t_overwriting;
   logic                  any_rdy;
   logic                  any_ow;
   logic [7:0]            next_rd_data;
   sdsf_status_type       status_word;

   // decodes a read strobe at one offset
   function automatic logic hit(input sdsf_read_type r, input logic [7:0] a);
      hit = r.strobe && (r.addr == a);
   endfunction

   // ----------------------------------------------------------------------
   // mode and transition decode
   // ----------------------------------------------------------------------
   // only 00 disables the fifo; 11 is treated as enabled too
   assign mode    = sdsf_fifo_mode_type'(fifo_mode);  // R19
   assign fifo_on = (mode != SDSF_FIFO_OFF);          // R19

   // active_mode is same-clock logic, so a plain edge detect is enough;
   // resets high so a level held through reset is no false entry edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_prev <= 1'b1;
      end else begin
         active_prev <= active_mode;
      end
   end

   assign zero = active_mode & ~active_prev;  // R20

   // retrieval strobes; the fifo port answers at 01h and at its own offset
   assign p_fetch    = ~fifo_on & hit(rd, `SDSF_ADDR_P_HIGH);  // R9
   assign t_fetch    = ~fifo_on & hit(rd, `SDSF_ADDR_T_HIGH);  // R11
   assign fifo_fetch = fifo_on & (hit(rd, `SDSF_ADDR_P_HIGH)
                                | hit(rd, `SDSF_ADDR_FIFO_PORT));  // R7
   assign p_retrieve   = p_fetch | fifo_fetch;  // R7
   assign t_retrieve   = t_fetch | fifo_fetch;  // R7
   assign any_retrieve = p_fetch | t_fetch | fifo_fetch;  // R6

   // ----------------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------------
   sdsf_channel #(
      .WIDTH       (P_WIDTH)
   ) u_pressure (
      .clk         (clk),
      .reset_n     (reset_n),
      .zero        (zero),
      .done        (p_done),
      .sample      (p_sample),
      .enable      (event_config.pressure_event_enable),  // R16
      .retrieve    (p_retrieve),
      .result      (p_result),
      .ready       (sample_status.pressure_ready_flag),  // R13
      .overwrite   (sample_status.pressure_overwrite_flag),  // R8
      .unread      (p_unread),
      .overwriting (p_overwriting)
   );

   sdsf_channel #(
      .WIDTH       (T_WIDTH)
   ) u_temp (
      .clk         (clk),
      .reset_n     (reset_n),
      .zero        (zero),
      .done        (t_done),
      .sample      (t_sample),
      .enable      (event_config.temp_event_enable),  // R17
      .retrieve    (t_retrieve),
      .result      (t_result),
      .ready       (sample_status.temp_ready_flag),  // R14
      .overwrite   (sample_status.temp_overwrite_flag),  // R10
      .unread      (t_unread),
      .overwriting (t_overwriting)
   );

   // ----------------------------------------------------------------------
   // combined flags
   // ----------------------------------------------------------------------
   // with the generator on, new data beats a read clear arriving in the same cycle; entry to active mode beats both
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         any_rdy <= 1'b0;
         any_ow  <= 1'b0;
      end else if (zero) begin
         any_rdy <= 1'b0;
         any_ow  <= 1'b0;
      end else begin
         any_rdy <= ((p_done | t_done)
                     & event_config.ready_event_generator_enable)
                  | (any_rdy & ~any_retrieve);  // R12 R15
         any_ow  <= ((p_overwriting | t_overwriting)
                     & event_config.ready_event_generator_enable)
                  | (any_ow & ~any_retrieve);  // R5 R6 R15
      end
   end

   assign sample_status.any_ready_flag     = any_rdy;  // R12
   assign sample_status.any_overwrite_flag = any_ow;   // R5
   assign sample_status.reserved_hi        = 1'b0;     // R4
   assign sample_status.reserved_lo        = 1'b0;     // R4
   assign status_word                      = sample_status;  // R3

   // altitude tag follows the pressure result, zeroed with it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pressure_is_altitude <= 1'b0;
      end else if (zero) begin
         pressure_is_altitude <= 1'b0;
      end else if (p_done) begin
         pressure_is_altitude <= height_mode_select;  // R18
      end
   end

   // ----------------------------------------------------------------------
   // read-back mux
   // ----------------------------------------------------------------------
   // result bytes are live only with the fifo off; fifo mode reads zeros, except 01h which returns fifo data
   always_comb begin
      next_rd_data = `SDSF_RESERVED_READ;
      case (rd.addr)
         `SDSF_ADDR_ALIAS: begin
            next_rd_data = fifo_on ? fifo_status : status_word;  // R1 R2
         end
         `SDSF_ADDR_P_HIGH: begin
            next_rd_data = fifo_on ? fifo_data
                                   : p_result[P_WIDTH-1 -: 8];  // R2 R18
         end
         `SDSF_ADDR_P_MID: begin
            if (!fifo_on) begin
               next_rd_data = p_result[P_WIDTH-9 -: 8];
            end
         end
         `SDSF_ADDR_P_LOW: begin
            if (!fifo_on) begin
               next_rd_data = {p_result[3:0], 4'h0};
            end
         end
         `SDSF_ADDR_T_HIGH: begin
            if (!fifo_on) begin
               next_rd_data = t_result[T_WIDTH-1 -: 8];
            end
         end
         `SDSF_ADDR_T_LOW: begin
            if (!fifo_on) begin
               next_rd_data = {t_result[3:0], 4'h0};
            end
         end
         `SDSF_ADDR_SAMPLE_ST: begin
            next_rd_data = status_word;  // R3
         end
         `SDSF_ADDR_FIFO_ST: begin
            next_rd_data = fifo_status;
         end
         `SDSF_ADDR_FIFO_PORT: begin
            next_rd_data = fifo_data;
         end
         default: begin
            next_rd_data = `SDSF_RESERVED_READ;
         end
      endcase
   end

   // data captured on the strobe edge, so status read before clearing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data  <= `SDSF_STATUS_RESET;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd.strobe;
         if (rd.strobe) begin
            rd_data <= next_rd_data;
         end
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_alias_sample;
      @(posedge clk) disable iff (!reset_n)
      hit(rd, `SDSF_ADDR_ALIAS) && !fifo_on
         |=> rd_valid && rd_data == $past(status_word);
   endproperty
   a_alias_sample: assert property (p_alias_sample)  // R1
      else $error("alias did not return sample status");

   property p_alias_fifo;
      @(posedge clk) disable iff (!reset_n)
      hit(rd, `SDSF_ADDR_ALIAS) && fifo_on
         |=> rd_data == $past(fifo_status);
   endproperty
   a_alias_fifo: assert property (p_alias_fifo)  // R1
      else $error("alias did not return fifo status");

   property p_reserved_zero;
      @(posedge clk) disable iff (!reset_n)
      rd.strobe && rd.addr == `SDSF_ADDR_SAMPLE_ST
         |=> rd_data[4] == 1'b0 && rd_data[0] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)  // R4
      else $error("reserved status bit read as one");

   property p_pressure_ow_set;
      @(posedge clk) disable iff (!reset_n)
      p_done && p_unread && event_config.pressure_event_enable && !zero
         |=> sample_status.pressure_overwrite_flag;
   endproperty
   a_pressure_ow_set: assert property (p_pressure_ow_set)  // R8
      else $error("pressure overwrite not flagged");

   property p_pressure_clear;
      @(posedge clk) disable iff (!reset_n)
      p_fetch && !p_done
         |=> !sample_status.pressure_ready_flag
             && !sample_status.pressure_overwrite_flag;
   endproperty
   a_pressure_clear: assert property (p_pressure_clear)  // R9
      else $error("pressure flags survived high byte read");

   property p_fifo_clear;
      @(posedge clk) disable iff (!reset_n)
      fifo_fetch && !p_done && !t_done |=> status_word == `SDSF_STATUS_RESET;
   endproperty
   a_fifo_clear: assert property (p_fifo_clear)  // R7
      else $error("fifo port read left a flag set");

   property p_combined_gate;
      @(posedge clk) disable iff (!reset_n)
      !any_rdy && !event_config.ready_event_generator_enable |=> !any_rdy;
   endproperty
   a_combined_gate: assert property (p_combined_gate)  // R15
      else $error("combined ready set while generator off");

   property p_same_cycle;
      @(posedge clk) disable iff (!reset_n)
      t_done && event_config.temp_event_enable && !zero
         |=> sample_status.temp_ready_flag && t_result == $past(t_sample);
   endproperty
   a_same_cycle: assert property (p_same_cycle)  // R21 R14
      else $error("temperature result and ready out of step");

   property p_active_zero;
      @(posedge clk) disable iff (!reset_n)
      zero |=> status_word == `SDSF_STATUS_RESET && p_result == '0;
   endproperty
   a_active_zero: assert property (p_active_zero)  // R20
      else $error("status not zeroed on entering active mode");

   property p_combined_ow;
      @(posedge clk) disable iff (!reset_n)
      (p_overwriting || t_overwriting) && !zero
         && event_config.ready_event_generator_enable
         |=> any_ow [*1] ##0 sample_status.any_overwrite_flag;
   endproperty
   a_combined_ow: assert property (p_combined_ow)  // R5
      else $error("combined overwrite not flagged");

endmodule

`default_nettype wire

//--- tb/sdsf_host_model.sv
// Purpose: host model that reads bytes over the block's read port
// Assumes: one byte per clock, strobe held up through a burst
// Notes:   idle address is inverted so a stale address never matches
`timescale 1ns/1ps
`default_nettype none

module sdsf_host_model (
   input  wire logic                    clk,
   input  wire logic [7:0]              rd_data,
   input  wire logic                    rd_valid,
   output var  sdsf_pkg::sdsf_read_type rd
);
   import sdsf_pkg::*;

   logic [7:0] rbuf [8];

   // idle at time zero
   initial begin
      rd.strobe = 1'b0;
      rd.addr   = 8'h5a;
   end

   // ----------------------------------------------------------------------
   // burst read
   // ----------------------------------------------------------------------
   // the host steps the address itself; a missing valid leaves unknowns
   task automatic burst(input logic [7:0] start, input int n);
      for (int k = 0; k < n; k++) begin
         rd.strobe = 1'b1;
         rd.addr   = start + 8'(k);
         @(posedge clk);
         #1;
         rbuf[k] = rd_valid ? rd_data : 8'hxx;
      end
      rd.strobe = 1'b0;
      rd.addr   = ~rd.addr;
      // one idle cycle so the next burst never lands in this time step
      @(posedge clk);
      #1;
   endtask

endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: self-checking bench for the sample status flags
// Assumes: inputs change 1 ns after the rising clock edge
// Notes:   fifo bytes are fixed levels; host model issues every read
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import sdsf_pkg::*;

   localparam int       LIMIT   = 3000;
   localparam logic [2:0] CFG [4] = '{3'b000, 3'b011, 3'b100, 3'b101};
   localparam logic [7:0] EXP [4] = '{8'h00, 8'h06, 8'h08, 8'h0a};

   logic                  clk;
   logic                  reset_n;
   logic                  active_mode;
   logic [1:0]            fifo_mode;
   sdsf_event_config_type event_config;
   logic                  height_mode_select;
   logic                  p_done;
   logic [19:0]           p_sample;
   logic                  t_done;
   logic [11:0]           t_sample;
   logic [7:0]            fifo_status;
   logic [7:0]            fifo_data;
   sdsf_read_type         rd;
   logic [7:0]            rd_data;
   logic                  rd_valid;
   sdsf_status_type       sample_status;
   logic                  pressure_is_altitude;
   int                    fails  = 0;
   int                    checks = 0;
   int                    cycles = 0;

   sdsf_status_flags u_sdsf_status_flags (
      .clk                  (clk),
      .reset_n              (reset_n),
      .active_mode          (active_mode),
      .fifo_mode            (fifo_mode),
      .event_config         (event_config),
      .height_mode_select   (height_mode_select),
      .p_done               (p_done),
      .p_sample             (p_sample),
      .t_done               (t_done),
      .t_sample             (t_sample),
      .fifo_status          (fifo_status),
      .fifo_data            (fifo_data),
      .rd                   (rd),
      .rd_data              (rd_data),
      .rd_valid             (rd_valid),
      .sample_status        (sample_status),
      .pressure_is_altitude (pressure_is_altitude)
   );

   sdsf_host_model u_sdsf_host_model (
      .clk      (clk),
      .rd_data  (rd_data),
      .rd_valid (rd_valid),
      .rd       (rd)
   );

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // done pulses held n cycles; n above 1 overwrites unread data
   task automatic pulse(input logic p, input logic t, input int n,
                        input logic [19:0] ps, input logic [11:0] ts);
      p_sample = ps;
      t_sample = ts;
      p_done   = p;
      t_done   = t;
      repeat (n) tick();
      p_done = 1'b0;
      t_done = 1'b0;
      tick();
   endtask

   task automatic stop_test();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      reset_n            = 1'b0;
      active_mode        = 1'b1;
      fifo_mode          = 2'h0;
      event_config       = 3'b111;
      height_mode_select = 1'b0;
      p_done             = 1'b0;
      p_sample           = 20'h00000;
      t_done             = 1'b0;
      t_sample           = 12'h000;
      fifo_status        = 8'h5a;
      fifo_data          = 8'h3c;
      repeat (20) @(posedge clk);
      #1;
      reset_n = 1'b1;
      chk(sample_status, 8'h00);
      u_sdsf_host_model.burst(8'h06, 1);
      chk(u_sdsf_host_model.rbuf[0], 8'h00);
      // one pressure sample, then a burst from the alias
      pulse(1'b1, 1'b0, 1, 20'habcde, 12'h000);
      chk(sample_status, 8'h0c);
      u_sdsf_host_model.burst(8'h00, 6);
      chk(u_sdsf_host_model.rbuf[0], 8'h0c);
      chk(u_sdsf_host_model.rbuf[1], 8'hab);
      chk(u_sdsf_host_model.rbuf[2], 8'hcd);
      chk(u_sdsf_host_model.rbuf[3], 8'he0);
      chk(sample_status, 8'h00);
      // back-to-back samples on both channels overwrite unread data
      pulse(1'b1, 1'b1, 2, 20'h12345, 12'hfed);
      chk(sample_status, 8'hee);
      u_sdsf_host_model.burst(8'h04, 2);
      chk(u_sdsf_host_model.rbuf[0], 8'hfe);
      chk(u_sdsf_host_model.rbuf[1], 8'hd0);
      chk(sample_status, 8'h44);
      u_sdsf_host_model.burst(8'h01, 1);
      chk(u_sdsf_host_model.rbuf[0], 8'h12);
      chk(sample_status, 8'h00);
      // flag generation gated by each enable; reads retrieve both
      for (int i = 0; i < 4; i++) begin
         event_config = CFG[i];
         pulse(1'b1, 1'b1, 1, 20'h00001, 12'h001);
         chk(sample_status, EXP[i]);
         u_sdsf_host_model.burst(8'h01, 4);
      end
      event_config = 3'b111;
      // every nonzero fifo mode swaps the alias and the clear source
      for (int m = 1; m < 4; m++) begin
         fifo_mode = 2'(m);
         pulse(1'b1, 1'b1, 1, 20'h00002, 12'h002);
         chk(sample_status, 8'h0e);
         u_sdsf_host_model.burst(8'h0d, 2);
         chk(u_sdsf_host_model.rbuf[0], 8'h5a);
         chk(u_sdsf_host_model.rbuf[1], 8'h3c);
         chk(sample_status, 8'h00);
         pulse(1'b1, 1'b1, 1, 20'h00003, 12'h003);
         u_sdsf_host_model.burst(8'h00, 3);
         chk(u_sdsf_host_model.rbuf[0], 8'h5a);
         chk(u_sdsf_host_model.rbuf[1], 8'h3c);
         chk(u_sdsf_host_model.rbuf[2], 8'h00);
         chk(sample_status, 8'h00);
      end
      fifo_mode = 2'h0;
      // altitude mode captured with the sample
      height_mode_select = 1'b1;
      pulse(1'b1, 1'b0, 1, 20'h00abc, 12'h000);
      chk({7'h00, pressure_is_altitude}, 8'h01);
      height_mode_select = 1'b0;
      // standby then active zeroes flags and results
      active_mode = 1'b0;
      tick();
      active_mode = 1'b1;
      tick();
      tick();
      chk(sample_status, 8'h00);
      chk({7'h00, pressure_is_altitude}, 8'h00);
      u_sdsf_host_model.burst(8'h01, 3);
      chk(u_sdsf_host_model.rbuf[0], 8'h00);
      chk(u_sdsf_host_model.rbuf[1], 8'h00);
      stop_test();
   end

endmodule
`default_nettype wire
